// ==== rsl_top.sv ====
// Operation
// RULE1: power strap: float on, down off, up charge
// RULE2: capture straps at reset, hold until next
// RULE3: speed strap low 30MHz, high 60MHz
// RULE4: speed strap sampled at every reset release
// RULE5: sense pin pulled down means non-removable
// RULE6: software bit disables strap decoding; code disables only port straps, speed and mode straps still decoded
// RULE7: board avoids straps without power switching
// RULE8: charge-off pull-up only after mode sampled
// RULE9: reset pulse held low at least 1us; the first do_reset holds it low only 4 cycles
// RULE10: after reset sense pins flag over-current
// RULE11: one reference clock drives everything
// RULE12: mode strap high legacy, else advanced
// RULE13: outputs stable, valid once capture done
//
// The register addresses and register access over APB were chosen for this implementation.
module rsl_top
  import rsl_pkg::*;
#(
  parameter int SETTLE_CYCLES = RSL_SETTLE_CYC
)(
  input  wire logic                  SYS_CLK,
  input  wire logic                  RST_N,
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [7:0]            PADDR,
  input  wire logic [31:0]           PWDATA,
  input  wire logic [3:0]            PSTRB,
  output logic                       PREADY,
  output logic      [31:0]           PRDATA,
  output logic                       PSLVERR,
  input  wire logic [RSL_NPORTS-1:0] PORT_POWER_STRAP,
  input  wire logic [RSL_NPORTS-1:0] OVERCURRENT_SENSE,
  input  wire logic                  ROM_SPEED_SELECT_STRAP,
  input  wire logic                  BUS_MODE_STRAP,
  output logic                       STRAP_PULL_UP,
  output logic [RSL_NPORTS-1:0]      PORT_ENABLE,
  output logic [RSL_NPORTS-1:0]      CHARGE_ENABLE,
  output logic [RSL_NPORTS-1:0]      NON_REMOVABLE,
  output logic [RSL_NPORTS-1:0]      OVERCURRENT,
  output logic                       ROM_SPEED_60MHZ,
  output logic                       BUS_MODE_LEGACY,
  output logic                       CAPTURE_DONE,
  output logic                       DYNAMIC_CHARGE_PORT_OFF_LOW_PU_EN
);

  // returns {enable, charge}; weak pull only wins on a floating pin
  function automatic logic [1:0] rsl_decode(input logic hi, input logic lo);
    rsl_decode = {hi | lo, hi & lo};
  endfunction : rsl_decode

  function automatic logic rsl_mapped(input logic [7:0] addr);
    rsl_mapped = (addr == RSL_OFS_CTRL) || (addr == RSL_OFS_STATUS) ||
                 (addr == RSL_OFS_PORT) || (addr == RSL_OFS_RAW);
  endfunction : rsl_mapped

  logic [1:0]            rst_sync;
  logic                  rst_n;
  rsl_state_t            state;
  rsl_state_t            next_state;
  logic [7:0]            cnt;
  logic [7:0]            next_cnt;
  logic                  pull_up;
  logic                  next_pull_up;
  logic [RSL_NPORTS-1:0] raw_hi;
  logic [RSL_NPORTS-1:0] next_raw_hi;
  logic [RSL_NPORTS-1:0] raw_lo;
  logic [RSL_NPORTS-1:0] next_raw_lo;
  logic [RSL_NPORTS-1:0] raw_ocs;
  logic [RSL_NPORTS-1:0] next_raw_ocs;
  logic                  raw_spd;
  logic                  next_raw_spd;
  logic                  raw_bus;
  logic                  next_raw_bus;
  logic                  done;
  logic                  next_done;
  rsl_cfg_t              cfg;
  rsl_cfg_t              next_cfg;
  logic [RSL_NPORTS-1:0] oc;
  logic [RSL_NPORTS-1:0] next_oc;
  logic                  cap_done;
  logic                  strap_dis;
  logic                  next_strap_dis;
  logic                  pready;
  logic                  next_pready;
  logic [31:0]           prdata;
  logic [31:0]           next_prdata;
  logic                  pslverr;
  logic                  next_pslverr;

  // reset release through two flops, async assert
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // capture sequence: weak pull high, then low, sample each
  always_comb
  begin
    next_state   = state;
    next_cnt     = cnt;
    next_pull_up = pull_up;
    next_raw_hi  = raw_hi;
    next_raw_lo  = raw_lo;
    next_raw_ocs = raw_ocs;
    next_raw_spd = raw_spd;
    next_raw_bus = raw_bus;
    next_done    = done;
    unique case (state)
      RSL_IDLE:
      begin
        next_state   = RSL_PULL_HI;
        next_pull_up = 1'b1;
        next_cnt     = RSL_CNT_RST;
      end
      RSL_PULL_HI:
      begin
        if (cnt == 8'(SETTLE_CYCLES - 1))
        begin
          next_raw_hi  = PORT_POWER_STRAP; // [RULE2]
          next_pull_up = 1'b0;
          next_cnt     = RSL_CNT_RST;
          next_state   = RSL_PULL_LO;
        end
        else
          next_cnt = cnt + 8'h01;
      end
      RSL_PULL_LO:
      begin
        if (cnt == 8'(SETTLE_CYCLES - 1))
        begin
          next_raw_lo  = PORT_POWER_STRAP;       // [RULE2]
          next_raw_ocs = OVERCURRENT_SENSE;      // [RULE5]
          next_raw_spd = ROM_SPEED_SELECT_STRAP; // [RULE4]
          next_raw_bus = BUS_MODE_STRAP;         // [RULE12]
          next_done    = 1'b1;
          next_state   = RSL_DONE;
        end
        else
          next_cnt = cnt + 8'h01;
      end
      RSL_DONE:
      begin
        next_state = RSL_DONE; // held until the next reset [RULE2]
      end
    endcase
  end

  // single reference clock for all state [RULE11]
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state   <= RSL_IDLE;
      cnt     <= RSL_CNT_RST;
      pull_up <= 1'b0;
      raw_hi  <= '0;
      raw_lo  <= '0;
      raw_ocs <= '0;
      raw_spd <= 1'b0;
      raw_bus <= 1'b0;
      done    <= 1'b0;
    end
    else
    begin
      state   <= next_state;
      cnt     <= next_cnt;
      pull_up <= next_pull_up;
      raw_hi  <= next_raw_hi;
      raw_lo  <= next_raw_lo;
      raw_ocs <= next_raw_ocs;
      raw_spd <= next_raw_spd;
      raw_bus <= next_raw_bus;
      done    <= next_done;
    end
  end

  // decoded settings; held at reset values until capture ends
  always_comb
  begin
    next_cfg = cfg;
    next_oc  = '0;
    if (done)
    begin
      for (int i = 0; i < RSL_NPORTS; i++)
      begin
        {next_cfg.port_en[i], next_cfg.charge_en[i]} = rsl_decode(raw_hi[i], raw_lo[i]); // [RULE1]
      end
      next_cfg.non_rem  = ~raw_ocs; // [RULE5]
      next_cfg.rom_fast = raw_spd;  // [RULE3]
      next_cfg.legacy   = raw_bus;  // [RULE12]
      if (strap_dis)
      begin
        // port straps ignored: all ports on, no charging, removable; speed and mode straps still decoded [RULE6]
        next_cfg.port_en   = '1;
        next_cfg.charge_en = '0;
        next_cfg.non_rem   = '0;
      end
      next_oc = ~OVERCURRENT_SENSE; // active-low sense pin [RULE10]
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg      <= RSL_CFG_RST;
      oc       <= '0;
      cap_done <= 1'b0;
    end
    else
    begin
      cfg      <= next_cfg;
      oc       <= next_oc;
      cap_done <= done; // lags cfg by none: both valid together [RULE13]
    end
  end

  assign STRAP_PULL_UP                     = pull_up;
  assign PORT_ENABLE                       = cfg.port_en;
  assign CHARGE_ENABLE                     = cfg.charge_en;
  assign NON_REMOVABLE                     = cfg.non_rem;
  assign ROM_SPEED_60MHZ                   = cfg.rom_fast;
  assign BUS_MODE_LEGACY                   = cfg.legacy;
  assign OVERCURRENT                       = oc;
  assign CAPTURE_DONE                      = cap_done;
  assign DYNAMIC_CHARGE_PORT_OFF_LOW_PU_EN = cap_done; // [RULE8]

  // apb slave, one wait state so read data comes from a flop
  always_comb
  begin
    next_pready    = PSEL & PENABLE & ~pready;
    next_prdata    = prdata;
    next_pslverr   = 1'b0;
    next_strap_dis = strap_dis;
    if (PSEL && PENABLE && !pready)
    begin
      next_pslverr = ~rsl_mapped(PADDR);
      next_prdata  = 32'h0000_0000;
      if (!PWRITE)
      begin
        unique case (PADDR)
          RSL_OFS_CTRL:   next_prdata[RSL_CTRL_DIS_BIT] = strap_dis;
          RSL_OFS_STATUS:
          begin
            next_prdata[RSL_ST_DONE_BIT]   = cap_done;
            next_prdata[RSL_ST_FAST_BIT]   = cfg.rom_fast;
            next_prdata[RSL_ST_LEGACY_BIT] = cfg.legacy;
          end
          RSL_OFS_PORT:
          begin
            next_prdata[RSL_PORT_EN_LSB +: RSL_NPORTS]   = cfg.port_en;
            next_prdata[RSL_PORT_CHG_LSB +: RSL_NPORTS]  = cfg.charge_en;
            next_prdata[RSL_PORT_NREM_LSB +: RSL_NPORTS] = cfg.non_rem;
            next_prdata[RSL_PORT_OC_LSB +: RSL_NPORTS]   = oc;
          end
          RSL_OFS_RAW:
          begin
            next_prdata[RSL_RAW_HI_LSB +: RSL_NPORTS]  = raw_hi;
            next_prdata[RSL_RAW_LO_LSB +: RSL_NPORTS]  = raw_lo;
            next_prdata[RSL_RAW_OCS_LSB +: RSL_NPORTS] = raw_ocs;
            next_prdata[RSL_RAW_SPD_BIT]               = raw_spd;
            next_prdata[RSL_RAW_BUS_BIT]               = raw_bus;
          end
          default: next_prdata = 32'h0000_0000;
        endcase
      end
    end
    // write lands only at the edge where pready is sampled high
    if (PSEL && PENABLE && pready && PWRITE && PSTRB[0] && (PADDR == RSL_OFS_CTRL))
      next_strap_dis = PWDATA[RSL_CTRL_DIS_BIT]; // [RULE6]
  end

  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready    <= 1'b0;
      prdata    <= 32'h0000_0000;
      pslverr   <= 1'b0;
      strap_dis <= RSL_CTRL_DIS_RST;
    end
    else
    begin
      pready    <= next_pready;
      prdata    <= next_prdata;
      pslverr   <= next_pslverr;
      strap_dis <= next_strap_dis;
    end
  end

  assign PREADY  = pready;
  assign PRDATA  = prdata;
  assign PSLVERR = pslverr;

  chk_port_enable: assert property (@(posedge SYS_CLK) disable iff (!rst_n) // [RULE1]
    done && !strap_dis |=> PORT_ENABLE == $past(raw_hi | raw_lo)) else $error("port enable decode wrong");
  chk_port_charge: assert property (@(posedge SYS_CLK) disable iff (!rst_n) // [RULE1]
    done && !strap_dis |=> CHARGE_ENABLE == $past(raw_hi & raw_lo)) else $error("charge decode wrong");
  chk_held_stable: assert property (@(posedge SYS_CLK) disable iff (!rst_n) // [RULE13]
    CAPTURE_DONE && $stable(strap_dis) |=> $stable(PORT_ENABLE) && $stable(NON_REMOVABLE))
    else $error("latched straps moved");
  chk_rom_speed: assert property (@(posedge SYS_CLK) disable iff (!rst_n) // [RULE3]
    CAPTURE_DONE |-> ROM_SPEED_60MHZ == raw_spd) else $error("rom speed mismatch");
  chk_capture_time: assert property (@(posedge SYS_CLK) disable iff (!rst_n) // [RULE4]
    $rose(rst_sync[1]) |-> ##[1:60] CAPTURE_DONE) else $error("capture late");
  chk_non_removable: assert property (@(posedge SYS_CLK) disable iff (!rst_n) // [RULE5]
    done && !strap_dis |=> NON_REMOVABLE == ~$past(raw_ocs)) else $error("non-removable wrong");
  chk_disable_dflt: assert property (@(posedge SYS_CLK) disable iff (!rst_n) // [RULE6]
    done && strap_dis |=> PORT_ENABLE == '1 && CHARGE_ENABLE == '0) else $error("disable ignored");
  chk_pullup_gate: assert property (@(posedge SYS_CLK) disable iff (!rst_n) // [RULE8]
    DYNAMIC_CHARGE_PORT_OFF_LOW_PU_EN |-> state == RSL_DONE && BUS_MODE_LEGACY == raw_bus)
    else $error("pull-up before mode sampled");
  chk_overcurrent: assert property (@(posedge SYS_CLK) disable iff (!rst_n) // [RULE10]
    done |=> OVERCURRENT == ~$past(OVERCURRENT_SENSE)) else $error("overcurrent flag wrong");
  chk_apb_wait: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
    PSEL && !PENABLE ##1 PSEL && PENABLE |=> PREADY) else $error("apb answer late");

  cov_done: cover property (@(posedge SYS_CLK) disable iff (!rst_n) $rose(CAPTURE_DONE));
  cov_charge: cover property (@(posedge SYS_CLK) disable iff (!rst_n) CAPTURE_DONE && |CHARGE_ENABLE);
  cov_disable: cover property (@(posedge SYS_CLK) disable iff (!rst_n) CAPTURE_DONE && strap_dis);
  cov_slverr: cover property (@(posedge SYS_CLK) disable iff (!rst_n) PREADY && PSLVERR);

endmodule : rsl_top

// ==== rsl_pkg.sv ====
package rsl_pkg;

  localparam int RSL_NPORTS = 4;

  // clock and strap settling time
  localparam int RSL_CLK_PERIOD_NS = 5;
  localparam int RSL_SETTLE_NS     = 100;
  localparam int RSL_SETTLE_CYC    = (RSL_SETTLE_NS + RSL_CLK_PERIOD_NS - 1) / RSL_CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] RSL_OFS_CTRL   = 8'h00;
  localparam logic [7:0] RSL_OFS_STATUS = 8'h04;
  localparam logic [7:0] RSL_OFS_PORT   = 8'h08;
  localparam logic [7:0] RSL_OFS_RAW    = 8'h0C;

  // field positions
  localparam int RSL_CTRL_DIS_BIT   = 0;
  localparam int RSL_ST_DONE_BIT    = 0;
  localparam int RSL_ST_FAST_BIT    = 1;
  localparam int RSL_ST_LEGACY_BIT  = 2;
  localparam int RSL_PORT_EN_LSB    = 0;
  localparam int RSL_PORT_CHG_LSB   = 4;
  localparam int RSL_PORT_NREM_LSB  = 8;
  localparam int RSL_PORT_OC_LSB    = 12;
  localparam int RSL_RAW_HI_LSB     = 0;
  localparam int RSL_RAW_LO_LSB     = 4;
  localparam int RSL_RAW_OCS_LSB    = 8;
  localparam int RSL_RAW_SPD_BIT    = 12;
  localparam int RSL_RAW_BUS_BIT    = 13;

  localparam logic       RSL_CTRL_DIS_RST = 1'b0;
  localparam logic [7:0] RSL_CNT_RST      = 8'h00;

  typedef struct packed {
    logic [RSL_NPORTS-1:0] port_en;
    logic [RSL_NPORTS-1:0] charge_en;
    logic [RSL_NPORTS-1:0] non_rem;
    logic                  rom_fast;
    logic                  legacy;
  } rsl_cfg_t;

  localparam rsl_cfg_t RSL_CFG_RST = '{default: '0};

  typedef enum logic [3:0] {
    RSL_IDLE    = 4'b0001,
    RSL_PULL_HI = 4'b0010,
    RSL_PULL_LO = 4'b0100,
    RSL_DONE    = 4'b1000
  } rsl_state_t;

endpackage : rsl_pkg

// ==== rsl_board.sv ====
module rsl_board
  import rsl_pkg::*;
(
  input  wire logic                    pull_up,
  input  wire logic [2*RSL_NPORTS-1:0] pwr_kind,
  input  wire logic [RSL_NPORTS-1:0]   oc_down,
  input  wire logic [RSL_NPORTS-1:0]   oc_fault,
  input  wire logic                    spd_up,
  input  wire logic                    mode_up,
  output logic      [RSL_NPORTS-1:0]   pwr_pin,
  output logic      [RSL_NPORTS-1:0]   oc_pin,
  output logic                         spd_pin,
  output logic                         mode_pin
);
  timeunit 1ns;
  timeprecision 100ps;

  // board always has power switching, so straps may be used
  always_comb
  begin
    for (int i = 0; i < RSL_NPORTS; i++)
    begin
      case (pwr_kind[2*i +: 2])
        2'h1:    pwr_pin[i] = 1'b0;
        2'h2:    pwr_pin[i] = 1'b1;
        default: pwr_pin[i] = pull_up; // open pin follows the weak bias
      endcase
      oc_pin[i] = ~(oc_down[i] | oc_fault[i]); // monitor pulls low on a fault
    end
  end

  assign spd_pin  = spd_up;
  assign mode_pin = mode_up;
endmodule : rsl_board

// ==== testbench.sv ====
module testbench;
  import rsl_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic        SYS_CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, spd, mode;
  logic [7:0]  PADDR, kind;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [3:0]  PSTRB, oc_down, oc_fault, pwr_pin, oc_pin, en, chg, nrem, oc;
  logic        spd_pin, mode_pin, pull_up, fast, legacy, done, pu_en, err;
  int          mismatches, checked;

  rsl_board board (.pull_up(pull_up), .pwr_kind(kind), .oc_down(oc_down), .oc_fault(oc_fault),
    .spd_up(spd), .mode_up(mode), .pwr_pin(pwr_pin), .oc_pin(oc_pin), .spd_pin(spd_pin), .mode_pin(mode_pin));

  rsl_top dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .PORT_POWER_STRAP(pwr_pin), .OVERCURRENT_SENSE(oc_pin), .ROM_SPEED_SELECT_STRAP(spd_pin),
    .BUS_MODE_STRAP(mode_pin), .STRAP_PULL_UP(pull_up), .PORT_ENABLE(en), .CHARGE_ENABLE(chg),
    .NON_REMOVABLE(nrem), .OVERCURRENT(oc), .ROM_SPEED_60MHZ(fast), .BUS_MODE_LEGACY(legacy),
    .CAPTURE_DONE(done), .DYNAMIC_CHARGE_PORT_OFF_LOW_PU_EN(pu_en));

  task end_of_test();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int n;
    @(posedge SYS_CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wr;
    PADDR   <= addr;
    PWDATA  <= wd;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do
    begin
      @(posedge SYS_CLK);
      n++;
    end
    while (PREADY !== 1'b1);
    check(n, 2); // exactly one wait state
    rd  = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task do_reset(input int cycles);
    int n;
    @(posedge SYS_CLK);
    RST_N <= 1'b0;
    repeat (cycles) @(posedge SYS_CLK);
    check(pu_en, 1'b0);
    RST_N <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    #1;
    check({done, pu_en, en}, 6'h00); // nothing valid before capture
    check(pull_up, 1'b1); // floating pins biased high first
    n = 0;
    while (done !== 1'b1 && n < 300)
    begin
      @(negedge SYS_CLK);
      n++;
    end
    check(done, 1'b1);
    check(pull_up, 1'b0); // bias back low after capture
  endtask : do_reset

  task check_cfg(input logic [3:0] e, input logic [3:0] c, input logic [3:0] r, input logic f, input logic l);
    check(en, e);
    check(chg, c);
    check(nrem, r);
    check(fast, f);
    check(legacy, l);
    check(pu_en, 1'b1);
  endtask : check_cfg

  task t_decode();
    check_cfg(4'hD, 4'h4, 4'h5, 1'b1, 1'b1);
  endtask : t_decode

  task t_hold_live();
    @(posedge SYS_CLK);
    kind    <= 8'hAA;
    oc_down <= 4'h0;
    spd     <= 1'b0;
    mode    <= 1'b0;
    repeat (10) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    check_cfg(4'hD, 4'h4, 4'h5, 1'b1, 1'b1); // later pin changes ignored
    @(posedge SYS_CLK);
    oc_fault <= 4'h8;
    repeat (3) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    check(oc, 4'h8);
    @(posedge SYS_CLK);
    oc_fault <= 4'h0;
    repeat (3) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    check(oc, 4'h0);
  endtask : t_hold_live

  task t_regs();
    apb(1'b0, RSL_OFS_STATUS, 32'h0);
    check(rd, 32'h0000_0007);
    apb(1'b0, RSL_OFS_PORT, 32'h0);
    check(rd, 32'h0000_054D);
    apb(1'b0, RSL_OFS_RAW, 32'h0);
    check(rd, 32'h0000_3A4D); // raw samples kept
    apb(1'b0, 8'h10, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0000_0000);
    apb(1'b1, RSL_OFS_CTRL, 32'h0000_0001);
    repeat (3) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    check_cfg(4'hF, 4'h0, 4'h0, 1'b1, 1'b1); // port strap decoding off
    apb(1'b0, RSL_OFS_CTRL, 32'h0);
    check(rd, 32'h0000_0001);
    apb(1'b1, RSL_OFS_CTRL, 32'h0);
    repeat (3) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    check_cfg(4'hD, 4'h4, 4'h5, 1'b1, 1'b1);
  endtask : t_regs

  task t_rereset();
    do_reset(200); // low pulse of 1us
    check_cfg(4'hF, 4'hF, 4'h0, 1'b0, 1'b0); // new straps taken at release
  endtask : t_rereset

  initial
  begin
    SYS_CLK = 1'b0;
    forever #2.5 SYS_CLK = ~SYS_CLK; // one reference clock
  end

  initial
  begin
    #50000;
    mismatches++;
    end_of_test();
  end

  initial
  begin
    mismatches = 0;
    checked    = 0;
    RST_N      = 1'b0;
    PSEL       = 1'b0;
    PENABLE    = 1'b0;
    PWRITE     = 1'b0;
    PADDR      = 8'h00;
    PWDATA     = 32'h0;
    PSTRB      = 4'hF;
    kind       = 8'h24; // port1 open, port2 down, port3 up, port4 open
    oc_down    = 4'h5;
    oc_fault   = 4'h0;
    spd        = 1'b1;
    mode       = 1'b1;
    do_reset(4);
    t_decode();
    t_hold_live();
    t_regs();
    t_rereset();
    end_of_test();
  end
endmodule : testbench
